// file: rtl/ret_rot_exec.sv
// Execution unit for return and rotate-through-carry instructions.
// Assumes a decoded instruction on i_instr with i_valid, i_file_data
// reading the file register at i_instr.faddr in the same cycle.
// Functional notes
// - Interrupt return pops stack, two cycles
// - Interrupt return sets global enable bit
// - Subroutine return pops stack, two cycles
// - Literal return loads working register, flags kept
// - Literal return reloads PC, two cycles
// - Rotate left through carry, one cycle
// - Rotate right through carry, one cycle
// - Destination bit picks working or file
`timescale 1ns/1ps
`include "ret_rot_params.svh"
module ret_rot_exec (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Instruction
   input wire logic i_valid,
   input wire ret_rot_pkg::instr_t i_instr,
   input wire logic [`DATA_W-1:0] i_file_data,
   // Stack push from call logic
   input wire logic i_push,
   input wire logic [`PC_W-1:0] i_push_addr,
   // State
   output logic o_busy,
   output logic [`PC_W-1:0] o_pc,
   output logic [`DATA_W-1:0] o_w,
   output logic o_carry,
   output logic [`DATA_W-1:0] o_irq_ctrl,
   output logic o_pc_load,
   output ret_rot_pkg::file_wr_t o_file_wr
);
   import ret_rot_pkg::*;

   logic [`PC_W-1:0] stack_reg [`STACK_DEPTH];
   logic [`SP_W-1:0] sp_reg;
   logic [1:0] cyc_reg;
   logic [`DATA_W-1:0] rot_res;
   logic rot_c;
   logic take;
   logic is_ret;
   logic is_rot;
   logic [`SP_W-1:0] top_idx;

   assign take = i_valid && !o_busy;
   assign is_ret = (i_instr.op == RETURN_FROM_INTERRUPT_OP) || (i_instr.op == RETURN_SUB_OP)
                   || (i_instr.op == RETURN_WITH_LITERAL_OP);
   assign is_rot = (i_instr.op == ROTATE_LEFT_CARRY_OP) || (i_instr.op == ROTATE_RIGHT_CARRY_OP);
   assign top_idx = sp_reg - 4'h1;

   rot_carry u_rot (
      .i_left(i_instr.op == ROTATE_LEFT_CARRY_OP),
      .i_src(i_file_data),
      .i_carry(o_carry),
      .o_res(rot_res),
      .o_carry(rot_c)
   );

   ////////////////////////////////////////////////////////////////////////
   // Return timing: second cycle is a flush slot
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_busy <= 1'b0;
         cyc_reg <= 2'h0;
      end else if (take && is_ret) begin
         o_busy <= 1'b1;
         cyc_reg <= `RET_CYCLES - 2'h1;
      end else if (o_busy) begin
         cyc_reg <= cyc_reg - 2'h1;
         o_busy <= (cyc_reg > 2'h1);
      end
   end

   chk_ret_two_cyc: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_ret |=> o_busy ##1 !o_busy)
      else $error("return not two cycles");

   chk_busy_refuse: assert property (@(posedge i_core_clk) disable iff (i_reset)
      o_busy && i_valid |=> !o_pc_load && !o_file_wr.wr)
      else $error("request taken in flush cycle");

   chk_rot_one_cyc: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_rot |=> !o_busy)
      else $error("rotate stalled the core");

   ////////////////////////////////////////////////////////////////////////
   // Call stack; circular, wraps on overflow or underflow
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         sp_reg <= 4'h0;
      end else if (take && is_ret) begin
         sp_reg <= top_idx;
      end else if (i_push) begin
         sp_reg <= sp_reg + 4'h1;
      end
   end

   for (genvar g = 0; g < `STACK_DEPTH; g++) begin : g_stack
      always_ff @(posedge i_core_clk) begin
         if (i_reset) begin
            stack_reg[g] <= `PC_RESET;
         end else if (i_push && !(take && is_ret) && sp_reg == `SP_W'(g)) begin
            stack_reg[g] <= i_push_addr;
         end
      end
   end

   chk_stack_pop: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_ret |=> sp_reg == $past(top_idx))
      else $error("stack not popped");

   ////////////////////////////////////////////////////////////////////////
   // Program counter
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_pc <= `PC_RESET;
         o_pc_load <= 1'b0;
      end else begin
         o_pc_load <= take && is_ret;
         if (take && is_ret) begin
            o_pc <= stack_reg[top_idx];
         end
      end
   end

   chk_ret_pc_load: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_ret |=> o_pc_load && o_pc == $past(stack_reg[top_idx]))
      else $error("return did not load popped address");

   chk_rot_keeps_pc: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_rot |=> !o_pc_load && $stable(o_pc))
      else $error("rotate moved program counter");

   ////////////////////////////////////////////////////////////////////////
   // Interrupt control: only the global enable is touched
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_irq_ctrl <= `IRQ_CTRL_RESET;
      end else if (take && i_instr.op == RETURN_FROM_INTERRUPT_OP) begin
         o_irq_ctrl[`GIE_BIT] <= 1'b1;
      end
   end

   chk_gie_set: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && i_instr.op == RETURN_FROM_INTERRUPT_OP |=> o_irq_ctrl[`GIE_BIT])
      else $error("global enable not set");

   chk_gie_only: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_ret |=> o_irq_ctrl[`GIE_BIT-1:0] == $past(o_irq_ctrl[`GIE_BIT-1:0]))
      else $error("return touched other control bits");

   ////////////////////////////////////////////////////////////////////////
   // Working register, carry and file write-back
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_w <= `W_RESET;
      end else if (take && i_instr.op == RETURN_WITH_LITERAL_OP) begin
         o_w <= i_instr.literal;
      end else if (take && is_rot && !i_instr.dest_file) begin
         o_w <= rot_res;
      end
   end

   chk_lit_to_w: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && i_instr.op == RETURN_WITH_LITERAL_OP |=> o_w == $past(i_instr.literal))
      else $error("literal not in working register");

   chk_ret_keeps_w: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_ret && i_instr.op != RETURN_WITH_LITERAL_OP |=> $stable(o_w))
      else $error("return changed working register");

   chk_rlf_result: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && i_instr.op == ROTATE_LEFT_CARRY_OP && !i_instr.dest_file
      |=> o_w == {$past(i_file_data[`MSB-1:0]), $past(o_carry)})
      else $error("rotate left wrong");

   chk_rrf_result: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && i_instr.op == ROTATE_RIGHT_CARRY_OP && !i_instr.dest_file
      |=> o_w == {$past(o_carry), $past(i_file_data[`MSB:1])})
      else $error("rotate right wrong");

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_carry <= 1'b0;
      end else if (take && is_rot) begin
         o_carry <= rot_c;
      end
   end

   chk_ret_flags: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_ret |=> $stable(o_carry))
      else $error("return changed carry");

   chk_rlf_carry: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && i_instr.op == ROTATE_LEFT_CARRY_OP |=> o_carry == $past(i_file_data[`MSB]))
      else $error("rotate left carry wrong");

   chk_rrf_carry: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && i_instr.op == ROTATE_RIGHT_CARRY_OP |=> o_carry == $past(i_file_data[0]))
      else $error("rotate right carry wrong");

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_file_wr <= '0;
      end else begin
         o_file_wr.wr <= take && is_rot && i_instr.dest_file;
         o_file_wr.addr <= i_instr.faddr;
         o_file_wr.data <= rot_res;
      end
   end

   chk_rot_dest: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_rot && i_instr.dest_file |=> o_file_wr.wr && o_file_wr.addr == $past(i_instr.faddr) && $stable(o_w))
      else $error("file destination wrong");

   chk_rot_w_dest: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && is_rot && !i_instr.dest_file |=> !o_file_wr.wr)
      else $error("file written for working destination");

   chk_rot_bits: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && i_instr.dest_file && i_instr.op == ROTATE_LEFT_CARRY_OP
      |=> o_file_wr.data == {$past(i_file_data[`MSB-1:0]), $past(o_carry)})
      else $error("rotate left file data wrong");

   chk_rrf_file: assert property (@(posedge i_core_clk) disable iff (i_reset)
      take && i_instr.dest_file && i_instr.op == ROTATE_RIGHT_CARRY_OP
      |=> o_file_wr.data == {$past(o_carry), $past(i_file_data[`MSB:1])})
      else $error("rotate right file data wrong");
endmodule : ret_rot_exec

// file: rtl/ret_rot_params.svh
// Constants for the return and rotate execution block.
// Assumes inclusion by the package and the design files.
`ifndef RET_ROT_PARAMS_SVH
`define RET_ROT_PARAMS_SVH
`define DATA_W 8
`define PC_W 15
`define FADDR_W 7
`define STACK_DEPTH 16
`define SP_W 4
`define RET_CYCLES 2'h2
`define ROT_CYCLES 2'h1
`define GIE_BIT 7
`define IRQ_CTRL_RESET 8'h00
`define W_RESET 8'h00
`define PC_RESET 15'h0000
`define MSB 7
`endif

// file: rtl/ret_rot_pkg.sv
// Types for the return and rotate execution block.
// Assumes ret_rot_params.svh is on the include path.
`include "ret_rot_params.svh"
package ret_rot_pkg;
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      RETURN_FROM_INTERRUPT_OP = 3'h1,
      RETURN_SUB_OP = 3'h2,
      RETURN_WITH_LITERAL_OP = 3'h3,
      ROTATE_LEFT_CARRY_OP = 3'h4,
      ROTATE_RIGHT_CARRY_OP = 3'h5
   } op_t;
   typedef struct packed {
      op_t op;
      logic [`DATA_W-1:0] literal;
      logic [`FADDR_W-1:0] faddr;
      logic dest_file;
   } instr_t;
   typedef struct packed {
      logic wr;
      logic [`FADDR_W-1:0] addr;
      logic [`DATA_W-1:0] data;
   } file_wr_t;
endpackage : ret_rot_pkg

// file: rtl/rot_carry.sv
// Combinational rotate through carry.
// Assumes caller supplies source byte and current carry.
`timescale 1ns/1ps
`include "ret_rot_params.svh"
module rot_carry (
   // Operands
   input wire logic i_left,
   input wire logic [`DATA_W-1:0] i_src,
   input wire logic i_carry,
   // Result
   output logic [`DATA_W-1:0] o_res,
   output logic o_carry
);
   always_comb begin
      if (i_left) begin
         o_res = {i_src[`MSB-1:0], i_carry};
         o_carry = i_src[`MSB];
      end else begin
         o_res = {i_carry, i_src[`MSB:1]};
         o_carry = i_src[0];
      end
   end
endmodule : rot_carry

// file: dv/tb_top.sv
// Self-checking bench for the return and rotate execution unit.
// Assumes ret_rot_pkg is compiled first; bench drives every port itself.
`timescale 1ns/1ps
`include "ret_rot_params.svh"
module tb_top;
   import ret_rot_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_valid = 1'b0;
   instr_t i_instr = '0;
   logic [`DATA_W-1:0] i_file_data = 8'h00;
   logic i_push = 1'b0;
   logic [`PC_W-1:0] i_push_addr = 15'h0000;
   logic o_busy;
   logic [`PC_W-1:0] o_pc;
   logic [`DATA_W-1:0] o_w;
   logic o_carry;
   logic [`DATA_W-1:0] o_irq_ctrl;
   logic o_pc_load;
   file_wr_t o_file_wr;
   int err_total = 0;
   int samples_checked = 0;
   ret_rot_exec ret_rot_exec_i (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_valid(i_valid),
      .i_instr(i_instr), .i_file_data(i_file_data), .i_push(i_push), .i_push_addr(i_push_addr),
      .o_busy(o_busy), .o_pc(o_pc), .o_w(o_w), .o_carry(o_carry), .o_irq_ctrl(o_irq_ctrl),
      .o_pc_load(o_pc_load), .o_file_wr(o_file_wr));
   initial begin
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   ////////////////////////////////////////////////////////////
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task summarize;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   task push(input logic [`PC_W-1:0] a);
      @(posedge i_core_clk) i_push <= 1'b1;
      i_push_addr <= a;
      @(posedge i_core_clk) i_push <= 1'b0;
   endtask : push
   // One-cycle request; returns just after the answer edge has settled
   task issue(input op_t op, input logic [7:0] k, input logic d, input logic [7:0] f);
      @(posedge i_core_clk) i_valid <= 1'b1;
      i_instr <= '{op, k, 7'h55, d};
      i_file_data <= f;
      @(posedge i_core_clk) i_valid <= 1'b0;
      #1;
   endtask : issue
   ////////////////////////////////////////////////////////////
   task check_idle;
      chk("reset pc", {1'b0, o_pc}, 16'h0000);
      chk("reset flags", {12'h000, o_busy, o_pc_load, o_carry, o_file_wr.wr}, 16'h0000);
      chk("reset w", {o_w, o_irq_ctrl}, 16'h0000);
   endtask : check_idle
   task t_rotate;
      issue(ROTATE_LEFT_CARRY_OP, 8'h00, 1'b0, 8'hE6);
      chk("rlf w", {8'h00, o_w}, 16'h00CC);
      chk("rlf busy c wr", {13'h0000, o_busy, o_carry, o_file_wr.wr}, 16'h0002);
      issue(ROTATE_RIGHT_CARRY_OP, 8'h00, 1'b1, 8'h01);
      chk("rrf wr", {o_file_wr.wr, o_file_wr.addr, o_file_wr.data}, 16'hD580);
      chk("rrf c w", {7'h00, o_carry, o_w}, 16'h01CC);
      issue(ROTATE_LEFT_CARRY_OP, 8'h00, 1'b1, 8'h00);
      chk("rlf f", {6'h00, o_file_wr.wr, o_carry, o_file_wr.data}, 16'h0201);
      issue(ROTATE_RIGHT_CARRY_OP, 8'h00, 1'b0, 8'h81);
      chk("rrf w", {6'h00, o_file_wr.wr, o_carry, o_w}, 16'h0140);
   endtask : t_rotate
   task t_returns;
      push(15'h1111);
      push(15'h2222);
      push(15'h3333);
      issue(RETURN_SUB_OP, 8'h00, 1'b0, 8'h00);
      chk("ret pc", {1'b0, o_pc}, 16'h3333);
      chk("ret load busy", {14'h0000, o_pc_load, o_busy}, 16'h0003);
      chk("ret flags", {7'h00, o_carry, o_w}, 16'h0140);
      chk("ret irq", {8'h00, o_irq_ctrl}, 16'h0000);
      issue(RETURN_FROM_INTERRUPT_OP, 8'h00, 1'b0, 8'h00);
      chk("reti pc", {1'b0, o_pc}, 16'h2222);
      chk("reti load busy", {14'h0000, o_pc_load, o_busy}, 16'h0003);
      chk("reti gie", {7'h00, o_carry, o_irq_ctrl}, 16'h0180);
      // Literal return held into the flush cycle: second request (literal 00) must be dropped
      @(posedge i_core_clk) i_valid <= 1'b1;
      i_instr <= '{RETURN_WITH_LITERAL_OP, 8'hFF, 7'h00, 1'b0};
      @(posedge i_core_clk) i_instr <= '{RETURN_WITH_LITERAL_OP, 8'h00, 7'h00, 1'b0};
      #1;
      chk("return_with_literal_op pc", {1'b0, o_pc}, 16'h1111);
      chk("return_with_literal_op load busy", {14'h0000, o_pc_load, o_busy}, 16'h0003);
      chk("return_with_literal_op w", {7'h00, o_carry, o_w}, 16'h01FF);
      @(posedge i_core_clk) i_valid <= 1'b0;
      #1;
      chk("return_with_literal_op drop", {6'h00, o_pc_load, o_busy, o_w}, 16'h00FF);
   endtask : t_returns
   // Mid-run reset must clear the enable bit and the stack pointer
   task t_reset;
      @(posedge i_core_clk) i_reset <= 1'b1;
      repeat (5) @(posedge i_core_clk);
      i_reset <= 1'b0;
      #1;
      check_idle();
      push(15'h4321);
      issue(RETURN_WITH_LITERAL_OP, 8'h5A, 1'b0, 8'h00);
      chk("post reset pc", {1'b0, o_pc}, 16'h4321);
      chk("post reset w", {7'h00, o_carry, o_w}, 16'h005A);
   endtask : t_reset
   ////////////////////////////////////////////////////////////
   initial begin
      #100000;
      err_total++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge i_core_clk);
      i_reset <= 1'b0;
      #1;
      check_idle();
      t_rotate();
      t_returns();
      t_reset();
      summarize();
   end
endmodule : tb_top
